// ---- dv/ppc_i2c_host.sv ----
// two-wire bus host model driving the block's serial pins
`timescale 1ns/1ps
module ppc_i2c_host #(
	parameter logic [6:0] DEV = 7'h25
) (
	output logic scl,
	output logic sdaLow,
	input wire logic sda
);
	// 80 ns bit; data moves late in the low phase so the slave's ack is gone first
	localparam time LO = 52;
	localparam time SU = 4;
	localparam time HI = 24;
	initial
	begin
		scl = 1'h1;
		sdaLow = 1'h0;
	end
	task automatic bitIo(input logic o, output logic i);
		#LO sdaLow = !o;
		#SU scl = 1'h1;
		#HI i = sda;
		scl = 1'h0;
	endtask : bitIo
	task automatic startCond;
		#LO sdaLow = 1'h0;
		#SU scl = 1'h1;
		#40 sdaLow = 1'h1;
		#40 scl = 1'h0;
	endtask : startCond
	task automatic stopCond;
		#LO sdaLow = 1'h1;
		#SU scl = 1'h1;
		#40 sdaLow = 1'h0;
		#40;
	endtask : stopCond
	task automatic byteIo(input logic [7:0] o, output logic [7:0] i);
		logic a;
		for (int k = 7; k >= 0; k--)
			bitIo(o[k], i[k]);
		// ninth bit released: slave acks, or host nacks a read byte
		bitIo(1'h1, a);
	endtask : byteIo
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] x;
		startCond();
		byteIo({DEV, 1'h0}, x);
		byteIo(a, x);
		byteIo(d, x);
		stopCond();
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		startCond();
		byteIo({DEV, 1'h0}, d);
		byteIo(a, d);
		startCond();
		byteIo({DEV, 1'h1}, d);
		byteIo(8'hFF, d);
		stopCond();
	endtask : rd
endmodule : ppc_i2c_host

// ---- dv/ppc_regs_asserts.sv ----
// pin-level checks for the port config and pushbutton register block
`timescale 1ns/1ps
module ppc_regs_asserts (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic oscMissingPin,
	input wire logic intRequest,
	input wire logic [3:0] portPowerOn,
	input wire logic [3:0] acProbeEn,
	input wire logic [3:0] detectEnable,
	input wire logic [3:0] classEnable,
	input wire logic [3:0] detectRun,
	input wire logic [3:0] portClear,
	input wire logic eventClearAll,
	input wire logic [3:0] icutFault,
	input wire logic [3:0] inrushFault,
	input wire logic [3:0] disconnectEvent,
	input wire logic oscFailSet,
	input wire logic intOe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	a_int_needs_req:
	assert property (intOe |-> $past(intRequest)) else $error("int pulled without request");
	a_clear_all_release:
	assert property (eventClearAll |-> ##[0:1] !intOe) else $error("int held through clear all");
	a_probe_when_on:
	assert property ((acProbeEn & ~portPowerOn) == 4'h0) else $error("probe on unpowered port");
	a_detect_when_off:
	assert property (((detectEnable | classEnable) & portPowerOn) == 4'h0)
		else $error("detect enabled on powered port");
	a_osc_quiet:
	assert property (!oscMissingPin [*6] |-> !oscFailSet) else $error("osc fail without cause");
	for (genvar i = 0; i < 4; i++)
	begin : g_port
		a_fault_cuts_power:
		assert property ((icutFault[i] || inrushFault[i] || disconnectEvent[i])
			|-> ##[0:1] !portPowerOn[i]) else $error("power stayed on after fault");
		a_clear_drops_power:
		assert property (portClear[i] |-> ##[0:1] !portPowerOn[i])
			else $error("power stayed on after port clear");
		a_fault_from_on:
		assert property (icutFault[i] |-> $past(portPowerOn[i]) || $past(portPowerOn[i], 2))
			else $error("overcurrent fault on unpowered port");
		a_run_single:
		assert property (detectRun[i] |=> !detectRun[i]) else $error("detect run longer than one");
	end
endmodule : ppc_regs_asserts
bind ppc_regs ppc_regs_asserts u_chk (.clk, .reset_n, .oscMissingPin, .intRequest, .portPowerOn,
	.acProbeEn, .detectEnable, .classEnable, .detectRun, .portClear, .eventClearAll, .icutFault,
	.inrushFault, .disconnectEvent, .oscFailSet, .intOe);

// ---- dv/ppc_regs_tb.sv ----
// self-checking bench for the port config and pushbutton register block
`timescale 1ns/1ps
module ppc_regs_tb;
	typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} ppc_row_s;
	ppc_row_s rows[14] = '{'{1'h0, 8'h12, 8'h00, 8'hFF}, '{1'h0, 8'h13, 8'h00, 8'h0F},
		'{1'h0, 8'h14, 8'h00, 8'hFF}, '{1'h0, 8'h16, 8'h00, 8'h00}, '{1'h0, 8'h17, 8'h00, 8'hA0},
		'{1'h1, 8'h16, 8'hFF, 8'h3F}, '{1'h1, 8'h16, 8'h00, 8'h00}, '{1'h1, 8'h12, 8'hE4, 8'hE4},
		'{1'h1, 8'h14, 8'h5A, 8'h4A}, '{1'h1, 8'h13, 8'h3C, 8'h3C}, '{1'h1, 8'h15, 8'h55, 8'h00},
		'{1'h1, 8'h18, 8'h00, 8'h00}, '{1'h1, 8'h19, 8'h00, 8'h00}, '{1'h1, 8'h1A, 8'h00, 8'h00}};
	logic clk = 1'h0;
	logic reset_n = 1'h0;
	logic strap = 1'h1;
	logic oscMiss = 1'h0;
	logic intReq = 1'h0;
	logic [3:0] belowMin = 4'h0;
	logic [3:0] acBelow = 4'h0;
	logic [3:0] overCut = 4'h0;
	logic scl, sdaLow, sdaOe, sdaOut, intOut, intOe, oscFail, clrAll;
	logic [3:0] power, probe, detEn, clsEn, detRun, clsRun, clr, overcurrent_cut_threshold, inr, disc;
	logic [3:0] seenClr = 4'h0, seenDet = 4'h0, seenCls = 4'h0, seenIcut = 4'h0, seenInr = 4'h0;
	logic [3:0] seenDisc = 4'h0;
	logic [3:0] detGood = 4'h0;
	logic seenAll = 1'h0;
	logic clrReq = 1'h0;
	int failures = 0;
	int checkCount = 0;
	wire sda = !(sdaLow || sdaOe);
	always #4 clk = !clk;
	ppc_i2c_host #(.DEV({ppc_pkg::DEV_ADDR_HI, 4'h5})) host (.scl(scl), .sdaLow(sdaLow), .sda(sda));
	ppc_regs #(.TICK_CYCLES(4)) dut (
		.clk(clk),
		.reset_n(reset_n),
		.clkEn(1'h1),
		.sclPin(scl),
		.sdaPin(sda),
		.sdaOut(sdaOut),
		.sdaOe(sdaOe),
		.devAddrPin(4'h5),
		.strapAutoPin(strap),
		.oscMissingPin(oscMiss),
		.belowMinHoldPin(belowMin),
		.acBelowMinPin(acBelow),
		.overCutPin(overCut),
		.detectGood(detGood),
		.intRequest(intReq),
		.portPowerOn(power),
		.acProbeEn(probe),
		.detectEnable(detEn),
		.classEnable(clsEn),
		.detectRun(detRun),
		.classRun(clsRun),
		.portClear(clr),
		.eventClearAll(clrAll),
		.icutFault(overcurrent_cut_threshold),
		.inrushFault(inr),
		.disconnectEvent(disc),
		.oscFailSet(oscFail),
		.intOut(intOut),
		.intOe(intOe)
	);
	// pulses are too short to meet a serial transfer, so latch them
	always @(posedge clk)
	begin
		if (clrReq)
			{seenClr, seenDet, seenCls, seenIcut, seenInr, seenDisc, seenAll} <= 25'h0;
		else
		begin
			seenClr <= seenClr | clr;
			seenDet <= seenDet | detRun;
			seenCls <= seenCls | clsRun;
			seenIcut <= seenIcut | overcurrent_cut_threshold;
			seenInr <= seenInr | inr;
			seenDisc <= seenDisc | disc;
			seenAll <= seenAll | clrAll;
		end
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checkCount++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle
	task automatic clrSeen;
		clrReq = 1'h1;
		settle(1);
		clrReq = 1'h0;
	endtask : clrSeen
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.wr(a, d);
		settle(8);
	endtask : wr
	task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		host.rd(a, v);
		chk("reg", e, v);
	endtask : rdChk
	task automatic stop_test;
		$display("checks %0d failures %0d", checkCount, failures);
		if (failures == 0 && checkCount > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test
	initial
	begin
		repeat (60000) @(posedge clk);
		failures++;
		stop_test();
	end
	initial
	begin
		settle(16);
		reset_n = 1'h1;
		settle(10);
		foreach (rows[i])
		begin
			if (rows[i].w)
				host.wr(rows[i].a, rows[i].d);
			rdChk(rows[i].a, rows[i].e);
		end
		wr(8'h12, 8'h55);
		wr(8'h19, 8'h0F);
		chk("power", 8'h0F, {4'h0, power});
		clrSeen();
		wr(8'h19, 8'h10);
		chk("power", 8'h0E, {4'h0, power});
		chk("clear", 8'h01, {4'h0, seenClr});
		wr(8'h12, 8'h54);
		wr(8'h19, 8'h01);
		chk("power", 8'h0E, {4'h0, power});
		wr(8'h13, 8'hCA);
		belowMin = 4'hF;
		acBelow = 4'h7;
		settle(2);
		chk("probe", 8'h0C, {4'h0, probe});
		settle(1200);
		chk("power", 8'h08, {4'h0, power});
		chk("disc", 8'h06, {4'h0, seenDisc});
		// wider window: the timer must still be counting down at the refused write
		wr(8'h16, 8'h08);
		overCut = 4'h8;
		settle(1100);
		chk("power", 8'h00, {4'h0, power});
		chk("overcurrent_cut_threshold", 8'h08, {4'h0, seenIcut});
		wr(8'h19, 8'h08);
		chk("power", 8'h00, {4'h0, power});
		overCut = 4'h0;
		settle(1200);
		wr(8'h19, 8'h08);
		chk("power", 8'h08, {4'h0, power});
		overCut = 4'h4;
		wr(8'h19, 8'h04);
		settle(400);
		chk("power", 8'h08, {4'h0, power});
		chk("inrush", 8'h04, {4'h0, seenInr});
		overCut = 4'h0;
		wr(8'h12, 8'h55);
		clrSeen();
		wr(8'h18, 8'h21);
		wr(8'h14, 8'h04);
		chk("detrun", 8'h05, {4'h0, seenDet});
		chk("clsrun", 8'h02, {4'h0, seenCls});
		wr(8'h12, 8'hFF);
		wr(8'h14, 8'h02);
		wr(8'h18, 8'h10);
		rdChk(8'h14, 8'h12);
		chk("clsen", 8'h01, {4'h0, clsEn});
		chk("deten", 8'h02, {4'h0, detEn});
		clrSeen();
		wr(8'h1A, 8'h08);
		chk("power", 8'h00, {4'h0, power});
		chk("clear", 8'h08, {4'h0, seenClr});
		detGood = 4'h8;
		settle(1);
		detGood = 4'h0;
		settle(2);
		chk("power", 8'h08, {4'h0, power});
		intReq = 1'h1;
		settle(4);
		chk("int", 8'h01, {7'h00, intOe});
		wr(8'h1A, 8'h40);
		chk("int", 8'h00, {7'h00, intOe});
		clrSeen();
		wr(8'h1A, 8'h80);
		chk("clrall", 8'h01, {7'h00, seenAll});
		chk("int", 8'h01, {7'h00, intOe});
		wr(8'h17, 8'h20);
		chk("int", 8'h00, {7'h00, intOe});
		oscMiss = 1'h1;
		settle(8);
		chk("oscfail", 8'h01, {7'h00, oscFail});
		wr(8'h17, 8'h00);
		chk("oscfail", 8'h00, {7'h00, oscFail});
		intReq = 1'h0;
		oscMiss = 1'h0;
		strap = 1'h0;
		wr(8'h1A, 8'h10);
		rdChk(8'h12, 8'h00);
		rdChk(8'h13, 8'h00);
		rdChk(8'h17, 8'hA0);
		chk("pins", 8'h00, {6'h00, intOut, sdaOut});
		stop_test();
	end
endmodule : ppc_regs_tb

// ---- include/ppc_pkg.sv ----
// constants and types shared by the port config and pushbutton register block
// Function
// R1: strap level loads every mode bit at power-up
// R2: two-bit mode field per port, four ports
// R3: dc enable removes power after low-current delay
// R4: ac enable probes port, removes power when open
// R5: presence ORed; no method enabled, never disconnect
// R6: enable bits gate auto/semi detect and classify
// R7: manual mode: set bit runs one cycle
// R8: timing fields 0-1, 2-3, 4-5; 6-7 zero
// R9: overcurrent past window flags fault, powers off
// R10: overcurrent past inrush window records fault, off
// R11: osc mask clear blocks osc-fail flag
// R12: int enable clear: never pull, ignore alert
// R13: pushbuttons write-only, one acts, read 00h
// R14: restart bit runs one manual-mode cycle
// R15: restart bit sets enable bit in auto/semi
// R16: power button sets/clears power except shutdown
// R17: faults and disconnects still cut button power
// R18: after fault, refuse power until timer zero
// R19: power-off button clears events, status, enables
// R20: reset bits 0-3 reset the matching port
// R21: bit 4 resets device, strap re-read
// R22: bit 6 releases int until cause clears
// R23: bit 7 releases int, clears all events
// R24: strap low shutdown, high auto; host changes
// R25: shutdown port: no detect, power, flags cleared
package ppc_pkg;
	localparam logic [7:0] ADDR_MODE = 8'h12;
	localparam logic [7:0] ADDR_DISC = 8'h13;
	localparam logic [7:0] ADDR_DETCLS = 8'h14;
	localparam logic [7:0] ADDR_TIMING = 8'h16;
	localparam logic [7:0] ADDR_MISC = 8'h17;
	localparam logic [7:0] ADDR_RESTART = 8'h18;
	localparam logic [7:0] ADDR_POWER = 8'h19;
	localparam logic [7:0] ADDR_RESET = 8'h1A;
	localparam logic [7:0] MISC_RESET = 8'hA0;
	localparam logic [5:0] TIMING_RESET = 6'h00;
	localparam int MISC_OSC_MASK_BIT = 5;
	localparam int MISC_INT_EN_BIT = 7;
	localparam int RST_ALL_BIT = 4;
	localparam int RST_INT_REL_BIT = 6;
	localparam int RST_CLR_ALL_BIT = 7;
	localparam int TIM_DIS_LSB = 0;
	localparam int TIM_OVERCURRENT_CUT_THRESHOLD_LSB = 2;
	localparam int TIM_START_LSB = 4;
	localparam logic [1:0] MODE_SHUT = 2'h0;
	localparam logic [1:0] MODE_MANUAL = 2'h1;
	localparam logic [1:0] MODE_SEMI = 2'h2;
	localparam logic [1:0] MODE_AUTO = 2'h3;
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [11:0] DIS_BASE_TICKS = 12'h100;
	localparam logic [11:0] OVERCURRENT_CUT_THRESHOLD_BASE_TICKS = 12'h040;
	localparam logic [11:0] START_BASE_TICKS = 12'h040;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;
	localparam logic [6:0] ARA_ADDR = 7'h0C;
	// arbitrary upper address bits of the serial slave
	localparam logic [2:0] DEV_ADDR_HI = 3'h2;
	typedef enum logic [2:0] {
		SL_IDLE = 3'h0,
		SL_RECV = 3'h1,
		SL_ACK = 3'h2,
		SL_SEND = 3'h3,
		SL_RACK = 3'h4
	} ppc_sl_e;
endpackage : ppc_pkg

// ---- include/ppc_reg_if.sv ----
// register access carrier between serial slave and register bank
`timescale 1ns/1ps
interface ppc_reg_if;
	logic wrStb;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic araEn;
	modport slave(output wrStb, output addr, output wdata, input rdata, input araEn);
	modport regs(input wrStb, input addr, input wdata, output rdata, output araEn);
endinterface : ppc_reg_if

// ---- verilog/ppc_regs.sv ----
// port configuration and pushbutton register bank with port power control
`timescale 1ns/1ps
module ppc_regs #(
	parameter int TICK_CYCLES = ppc_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic sclPin,
	input wire logic sdaPin,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic [3:0] devAddrPin,
	input wire logic strapAutoPin,
	input wire logic oscMissingPin,
	input wire logic [3:0] belowMinHoldPin,
	input wire logic [3:0] acBelowMinPin,
	input wire logic [3:0] overCutPin,
	input wire logic [3:0] detectGood,
	input wire logic intRequest,
	output logic [3:0] portPowerOn,
	output logic [3:0] acProbeEn,
	output logic [3:0] detectEnable,
	output logic [3:0] classEnable,
	output logic [3:0] detectRun,
	output logic [3:0] classRun,
	output logic [3:0] portClear,
	output logic eventClearAll,
	output logic [3:0] icutFault,
	output logic [3:0] inrushFault,
	output logic [3:0] disconnectEvent,
	output logic oscFailSet,
	output logic intOut,
	output logic intOe
);
	typedef struct packed {
		logic [1:0] strapS;
		logic [1:0] oscS;
		logic [1:0][3:0] belowS;
		logic [1:0][3:0] acBelS;
		logic [1:0][3:0] overS;
		logic [1:0] loadCnt;
		logic [7:0] mode;
		logic [7:0] discEn;
		logic [7:0] detCls;
		logic [5:0] timing;
		logic [7:0] misc;
		logic [3:0] power;
		logic [3:0] startDone;
		logic [3:0] faultLock;
		logic [16:0] tickCnt;
		logic tick;
		logic [3:0][11:0] disTmr;
		logic [3:0][11:0] ocTmr;
		logic [3:0][11:0] stTmr;
		logic [3:0] detRun;
		logic [3:0] clsRun;
		logic [3:0] portClr;
		logic clrAll;
		logic [3:0] evIcut;
		logic [3:0] evStart;
		logic [3:0] evDisc;
		logic oscFail;
		logic intRel;
		logic intDrive;
	} ppc_regs_s;
	ppc_regs_s r, nxt;

	ppc_reg_if regBus();

	ppc_serial_slave u_slave (
		.clk(clk),
		.reset_n(reset_n),
		.clkEn(clkEn),
		.sclPin(sclPin),
		.sdaPin(sdaPin),
		.devAddrPin(devAddrPin),
		.sdaOe(sdaOe),
		.bus(regBus.slave)
	);

	always_comb
	begin
		logic wr;
		logic [7:0] a;
		logic [7:0] d;
		logic [1:0] md;
		logic [11:0] winDis, winIcut, winStart;
		logic dcE, acE, present, busyMode;
		nxt = r;
		wr = regBus.wrStb;
		a = regBus.addr;
		d = regBus.wdata;
		md = 2'h0;
		dcE = 1'b0;
		acE = 1'b0;
		present = 1'b0;
		busyMode = 1'b0;
		nxt.strapS = {r.strapS[0], strapAutoPin};
		nxt.oscS = {r.oscS[0], oscMissingPin};
		nxt.belowS = {r.belowS[0], belowMinHoldPin};
		nxt.acBelS = {r.acBelS[0], acBelowMinPin};
		nxt.overS = {r.overS[0], overCutPin};
		nxt.detRun = 4'h0;
		nxt.clsRun = 4'h0;
		nxt.portClr = 4'h0;
		nxt.clrAll = 1'b0;
		nxt.evIcut = 4'h0;
		nxt.evStart = 4'h0;
		nxt.evDisc = 4'h0;
		nxt.tick = 1'b0;
		// windows double per field step
		winDis = ppc_pkg::DIS_BASE_TICKS << r.timing[ppc_pkg::TIM_DIS_LSB +: 2];
		winIcut = ppc_pkg::OVERCURRENT_CUT_THRESHOLD_BASE_TICKS << r.timing[ppc_pkg::TIM_OVERCURRENT_CUT_THRESHOLD_LSB +: 2];
		winStart = ppc_pkg::START_BASE_TICKS << r.timing[ppc_pkg::TIM_START_LSB +: 2];

		// shared millisecond tick keeps the per-port timers narrow
		if (r.tickCnt == 17'(TICK_CYCLES - 1))
		begin
			nxt.tickCnt = 17'h00000;
			nxt.tick = 1'b1;
		end
		else
			nxt.tickCnt = r.tickCnt + 17'h00001;

		// strap read a few cycles after reset so the synchroniser has filled
		if (r.loadCnt != 2'h0)
		begin
			nxt.loadCnt = r.loadCnt - 2'h1;
			if (r.loadCnt == 2'h1)
			begin
				nxt.mode = {8{r.strapS[1]}}; // [R1] [R24]
				nxt.detCls = {8{r.strapS[1]}};
				nxt.discEn = {4'h0, {4{r.strapS[1]}}};
			end
		end

		if (wr)
		begin
			if (a == ppc_pkg::ADDR_MODE)
				nxt.mode = d; // [R2] [R24]
			if (a == ppc_pkg::ADDR_DISC)
				nxt.discEn = d;
			if (a == ppc_pkg::ADDR_DETCLS)
				nxt.detCls = d; // [R6]
			if (a == ppc_pkg::ADDR_TIMING)
				nxt.timing = d[5:0]; // [R8]
			if (a == ppc_pkg::ADDR_MISC)
				nxt.misc = d;
		end

		for (int p = 0; p < 4; p++)
		begin
			md = nxt.mode[2*p +: 2];
			busyMode = (md == ppc_pkg::MODE_AUTO) || (md == ppc_pkg::MODE_SEMI);
			if (wr && md == ppc_pkg::MODE_MANUAL)
			begin
				// manual ports get one cycle per bit written as one
				if (a == ppc_pkg::ADDR_DETCLS || a == ppc_pkg::ADDR_RESTART)
				begin
					nxt.detRun[p] = d[p]; // [R7] [R14]
					nxt.clsRun[p] = d[p+4]; // [R7] [R14]
				end
			end
			if (wr && busyMode && a == ppc_pkg::ADDR_RESTART)
			begin
				nxt.detCls[p] = nxt.detCls[p] | d[p]; // [R15]
				nxt.detCls[p+4] = nxt.detCls[p+4] | d[p+4]; // [R15]
			end
			if (wr && a == ppc_pkg::ADDR_POWER)
			begin
				if (d[p] && md != ppc_pkg::MODE_SHUT
					&& !(r.faultLock[p] && r.ocTmr[p] != 12'h000)) // [R18]
					nxt.power[p] = 1'b1; // [R16]
				if (d[p+4])
				begin
					nxt.power[p] = 1'b0; // [R16]
					nxt.portClr[p] = 1'b1; // [R19]
					nxt.detCls[p] = 1'b0; // [R19]
					nxt.detCls[p+4] = 1'b0; // [R19]
				end
			end
			if (wr && a == ppc_pkg::ADDR_RESET && d[p])
			begin
				nxt.power[p] = 1'b0; // [R20]
				nxt.portClr[p] = 1'b1; // [R20]
				nxt.detCls[p] = 1'b0; // [R20]
				nxt.detCls[p+4] = 1'b0; // [R20]
			end
			// auto power-up after good detection; an off or port reset that cycle wins
			if (md == ppc_pkg::MODE_AUTO && detectGood[p] && !r.power[p] && !nxt.portClr[p]
				&& !(r.faultLock[p] && r.ocTmr[p] != 12'h000)) // [R18]
				nxt.power[p] = 1'b1;

			// overcurrent timer counts down when clear, so it also limits duty
			if (r.tick)
			begin
				if (r.power[p] && r.startDone[p] && r.overS[1][p])
				begin
					if (r.ocTmr[p] != 12'hFFF)
						nxt.ocTmr[p] = r.ocTmr[p] + 12'h001;
				end
				else if (r.ocTmr[p] != 12'h000)
					nxt.ocTmr[p] = r.ocTmr[p] - 12'h001;
			end
			if (r.faultLock[p] && r.ocTmr[p] == 12'h000)
				nxt.faultLock[p] = 1'b0; // [R18]
			if (r.power[p] && r.startDone[p] && r.ocTmr[p] >= winIcut)
			begin
				nxt.power[p] = 1'b0; // [R9] [R17]
				nxt.evIcut[p] = 1'b1; // [R9]
				nxt.faultLock[p] = 1'b1; // [R18]
			end

			// inrush: continuous overcurrent during power-on
			if (!r.power[p])
			begin
				nxt.startDone[p] = 1'b0;
				nxt.stTmr[p] = 12'h000;
			end
			else if (!r.overS[1][p])
			begin
				nxt.stTmr[p] = 12'h000;
				if (r.tick)
					nxt.startDone[p] = 1'b1;
			end
			else if (r.tick && !r.startDone[p])
				nxt.stTmr[p] = r.stTmr[p] + 12'h001;
			if (r.power[p] && !r.startDone[p] && r.stTmr[p] >= winStart)
			begin
				nxt.power[p] = 1'b0; // [R10] [R17]
				nxt.evStart[p] = 1'b1; // [R10]
				nxt.faultLock[p] = 1'b1; // [R18]
			end

			// disconnect: either enabled method seeing the load keeps power
			dcE = nxt.discEn[p];
			acE = nxt.discEn[p+4];
			present = (dcE & ~r.belowS[1][p]) | (acE & ~r.acBelS[1][p]); // [R5]
			if (!r.power[p] || !(dcE | acE) || present)
				nxt.disTmr[p] = 12'h000; // [R5]
			else if (r.tick && r.disTmr[p] != 12'hFFF)
				nxt.disTmr[p] = r.disTmr[p] + 12'h001;
			if (r.power[p] && (dcE | acE) && !present && r.disTmr[p] >= winDis)
			begin
				nxt.power[p] = 1'b0; // [R3] [R4] [R17]
				nxt.evDisc[p] = 1'b1;
			end

			// shutdown holds the port dead and its flags cleared
			if (md == ppc_pkg::MODE_SHUT)
			begin
				nxt.power[p] = 1'b0; // [R25]
				nxt.portClr[p] = 1'b1; // [R25]
				nxt.detCls[p] = 1'b0; // [R25]
				nxt.detCls[p+4] = 1'b0; // [R25]
				nxt.detRun[p] = 1'b0; // [R25]
				nxt.clsRun[p] = 1'b0; // [R25]
			end
		end

		// osc monitor gated by mask; supply event logic latches the flag
		nxt.oscFail = r.oscS[1] & r.misc[ppc_pkg::MISC_OSC_MASK_BIT]; // [R11]

		// interrupt pin release and re-arm
		if (!intRequest)
			nxt.intRel = 1'b0; // [R22]
		if (wr && a == ppc_pkg::ADDR_RESET && d[ppc_pkg::RST_INT_REL_BIT] && intRequest)
			nxt.intRel = 1'b1; // [R22]
		if (wr && a == ppc_pkg::ADDR_RESET && d[ppc_pkg::RST_CLR_ALL_BIT])
		begin
			nxt.clrAll = 1'b1; // [R23]
			nxt.intRel = 1'b0; // [R23]
		end
		nxt.intDrive = intRequest && nxt.misc[ppc_pkg::MISC_INT_EN_BIT] // [R12]
			&& !nxt.intRel && !nxt.clrAll; // [R22] [R23]

		// device-wide reset: like power-up, keeping the synchronisers and the millisecond tick counter
		if (wr && a == ppc_pkg::ADDR_RESET && d[ppc_pkg::RST_ALL_BIT])
		begin
			nxt.loadCnt = ppc_pkg::STRAP_SETTLE; // [R21]
			nxt.mode = 8'h00; // [R21]
			nxt.discEn = 8'h00;
			nxt.detCls = 8'h00;
			nxt.timing = ppc_pkg::TIMING_RESET;
			nxt.misc = ppc_pkg::MISC_RESET;
			nxt.power = 4'h0; // [R21]
			nxt.startDone = 4'h0;
			nxt.faultLock = 4'h0;
			nxt.disTmr = '0;
			nxt.ocTmr = '0;
			nxt.stTmr = '0;
			nxt.detRun = 4'h0;
			nxt.clsRun = 4'h0;
			nxt.portClr = 4'hF;
			nxt.clrAll = 1'b1;
			nxt.intRel = 1'b0;
			nxt.intDrive = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			r <= '0;
			r.loadCnt <= ppc_pkg::STRAP_SETTLE;
			r.misc <= ppc_pkg::MISC_RESET;
			r.timing <= ppc_pkg::TIMING_RESET;
		end
		else if (clkEn)
			r <= nxt;
	end

	// register read data; pushbutton and foreign addresses read zero
	always_comb
	begin
		case (regBus.addr)
			ppc_pkg::ADDR_MODE: regBus.rdata = r.mode;
			ppc_pkg::ADDR_DISC: regBus.rdata = r.discEn;
			ppc_pkg::ADDR_DETCLS: regBus.rdata = r.detCls;
			ppc_pkg::ADDR_TIMING: regBus.rdata = {2'h0, r.timing}; // [R8]
			ppc_pkg::ADDR_MISC: regBus.rdata = r.misc;
			default: regBus.rdata = 8'h00; // [R13]
		endcase
	end

	assign regBus.araEn = r.intDrive; // [R12]
	assign sdaOut = 1'b0;
	assign intOut = 1'b0;
	assign intOe = r.intDrive;
	assign portPowerOn = r.power;
	assign acProbeEn = r.power & r.discEn[7:4]; // [R4]
	assign detectEnable = r.detCls[3:0] & ~r.power & {r.mode[7], r.mode[5], r.mode[3],
		r.mode[1]}; // [R6]
	assign classEnable = r.detCls[7:4] & ~r.power & {r.mode[7], r.mode[5], r.mode[3],
		r.mode[1]}; // [R6]
	assign detectRun = r.detRun;
	assign classRun = r.clsRun;
	assign portClear = r.portClr;
	assign eventClearAll = r.clrAll;
	assign icutFault = r.evIcut;
	assign inrushFault = r.evStart;
	assign disconnectEvent = r.evDisc;
	assign oscFailSet = r.oscFail;
endmodule : ppc_regs

// ---- verilog/ppc_serial_slave.sv ----
// two-wire serial slave: byte framing, pointer, register strobes
`timescale 1ns/1ps
module ppc_serial_slave (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic sclPin,
	input wire logic sdaPin,
	input wire logic [3:0] devAddrPin,
	output logic sdaOe,
	ppc_reg_if.slave bus
);
	typedef struct packed {
		logic [1:0] sclS;
		logic [1:0] sdaS;
		logic sclP;
		logic sdaP;
		logic [3:0] adrS0;
		logic [3:0] adrS1;
		ppc_pkg::ppc_sl_e st;
		logic [3:0] bitCnt;
		logic [7:0] sh;
		logic [1:0] phase;
		logic isRead;
		logic isAra;
		logic [7:0] ptr;
		logic [7:0] wrAddr;
		logic wr;
		logic oe;
	} ppc_slave_s;
	ppc_slave_s r, nxt;

	always_comb
	begin
		logic scl, sda, rise, fall;
		logic [6:0] own;
		logic [7:0] ld;
		nxt = r;
		nxt.sclS = {r.sclS[0], sclPin};
		nxt.sdaS = {r.sdaS[0], sdaPin};
		nxt.sclP = r.sclS[1];
		nxt.sdaP = r.sdaS[1];
		nxt.adrS0 = devAddrPin;
		nxt.adrS1 = r.adrS0;
		nxt.wr = 1'b0;
		scl = r.sclS[1];
		sda = r.sdaS[1];
		rise = scl & ~r.sclP;
		fall = ~scl & r.sclP;
		own = {ppc_pkg::DEV_ADDR_HI, r.adrS1};
		ld = r.isAra ? {own, 1'b0} : bus.rdata;
		if (scl && r.sclP && r.sdaP && !sda)
		begin
			nxt.st = ppc_pkg::SL_RECV;
			nxt.bitCnt = 4'h0;
			nxt.phase = 2'h0;
			nxt.oe = 1'b0;
		end
		else if (scl && r.sclP && !r.sdaP && sda)
		begin
			nxt.st = ppc_pkg::SL_IDLE;
			nxt.oe = 1'b0;
		end
		else
		begin
			unique case (r.st)
				ppc_pkg::SL_IDLE: ;
				ppc_pkg::SL_RECV:
					if (rise)
					begin
						nxt.sh = {r.sh[6:0], sda};
						nxt.bitCnt = r.bitCnt + 4'h1;
					end
					else if (fall && r.bitCnt == 4'h8)
					begin
						nxt.st = ppc_pkg::SL_ACK;
						nxt.oe = 1'b1;
						nxt.phase = (r.phase == 2'h0) ? 2'h1 : 2'h2;
						if (r.phase == 2'h0)
						begin
							nxt.isRead = r.sh[0];
							nxt.isAra = r.sh[7:1] != own;
							// alert address answered only while int is live [R12]
							if (r.sh[7:1] != own && !(r.sh[7:1] == ppc_pkg::ARA_ADDR
								&& r.sh[0] && bus.araEn))
							begin
								nxt.st = ppc_pkg::SL_IDLE;
								nxt.oe = 1'b0;
							end
						end
						else if (r.phase == 2'h1)
							nxt.ptr = r.sh;
						else
						begin
							nxt.wr = 1'b1;
							nxt.wrAddr = r.ptr;
							nxt.ptr = r.ptr + 8'h01;
						end
					end
				ppc_pkg::SL_ACK:
					if (fall)
					begin
						nxt.bitCnt = 4'h0;
						nxt.st = r.isRead ? ppc_pkg::SL_SEND : ppc_pkg::SL_RECV;
						nxt.oe = r.isRead & ~ld[7];
						if (r.isRead)
							nxt.sh = ld;
						if (r.isRead && !r.isAra)
							nxt.ptr = r.ptr + 8'h01;
					end
				ppc_pkg::SL_SEND:
					if (fall)
					begin
						nxt.bitCnt = r.bitCnt + 4'h1;
						nxt.sh = {r.sh[6:0], 1'b0};
						nxt.oe = (r.bitCnt != 4'h7) & ~r.sh[6];
						if (r.bitCnt == 4'h7)
							nxt.st = ppc_pkg::SL_RACK;
					end
				ppc_pkg::SL_RACK:
					if (rise)
						nxt.st = sda ? ppc_pkg::SL_IDLE : ppc_pkg::SL_ACK;
				default: nxt.st = ppc_pkg::SL_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			r <= '0;
		else if (clkEn)
			r <= nxt;
	end

	assign sdaOe = r.oe;
	assign bus.wrStb = r.wr;
	assign bus.wdata = r.sh;
	assign bus.addr = r.wr ? r.wrAddr : r.ptr;
endmodule : ppc_serial_slave
